/* File: dchp_host_port.sv */
// Host port of a dual channel transceiver: parallel and SPI register access.
// Assumes pins are asynchronous to ref_clk_in; SPI clock is its own domain.
module dchp_host_port
    import dchp_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input  wire logic              ref_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              spi_sclk_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe_out,
    output logic                   miso_out,
    output logic                   miso_oe_out,
    input  wire logic              chan1_select_n_in,
    input  wire logic              chan2_select_n_in,
    input  wire logic              read_or_data_strobe_n_in,
    input  wire logic              write_or_direction_n_in,
    input  wire logic              bus_style_select_in,
    input  wire logic              spi_select_in,
    input  wire dchp_events_s      chan1_events_in,
    input  wire dchp_events_s      chan2_events_in,
    output logic                   irq_out_n_out,
    output logic                   irq_oe_out
);

    localparam int DEPTH  = 1 << ADDR_W;
    localparam int SYNC_W = 6 + ADDR_W + DCHP_DATA_W;

    // Elaboration check on address width
    if (ADDR_W < 2 || ADDR_W > DCHP_SPI_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W must lie between 2 and 14");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers in the register domain

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic              cs1_n_s;
    logic              cs2_n_s;
    logic              strobe_n_s;
    logic              dir_n_s;
    logic              bts_s;
    logic              spi_sel_s;
    logic [ADDR_W-1:0] addr_s;
    logic [7:0]        data_s;

    // Two flops before register-domain logic reads a pin
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_meta <= '1;
            sync_q    <= '1;
        end else begin
            sync_meta <= {chan1_select_n_in, chan2_select_n_in,
                          read_or_data_strobe_n_in, write_or_direction_n_in,
                          bus_style_select_in, spi_select_in,
                          addr_in, data_in};
            sync_q    <= sync_meta;
        end
    end

    assign {cs1_n_s, cs2_n_s, strobe_n_s, dir_n_s,
            bts_s, spi_sel_s, addr_s, data_s} = sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Parallel strobe decode

    wire cs1_act  = ~cs1_n_s;
    wire cs2_act  = ~cs2_n_s;
    wire sel_any  = cs1_act | cs2_act;
    wire sel_chan = ~cs1_act;
    wire par_mode = ~spi_sel_s;
    wire rd_req   = bts_s ? (~strobe_n_s & dir_n_s)
                          : ~strobe_n_s;
    wire wr_level = bts_s ? (~strobe_n_s & ~dir_n_s)
                          : ~dir_n_s;

    logic wr_level_q;

    // Previous write level, for the rising edge of the strobe
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_level_q <= 1'b0;
        end else begin
            wr_level_q <= wr_level;
        end
    end

    wire par_wr  = par_mode & sel_any & wr_level_q & ~wr_level;
    wire next_oe = par_mode & sel_any & rd_req;

    ////////////////////////////////////////////////////////////////////////
    // Serial write requests crossing into the register domain

    dchp_wreq_s wreq_hold;
    logic       wreq_tgl;
    logic       tgl_meta;
    logic       tgl_s;
    logic       tgl_q;

    // Toggle synchroniser, request word is written on the same link clock edge as the toggle
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tgl_meta <= 1'b0;
            tgl_s    <= 1'b0;
            tgl_q    <= 1'b0;
        end else begin
            tgl_meta <= wreq_tgl;
            tgl_s    <= tgl_meta;
            tgl_q    <= tgl_s;
        end
    end

    wire spi_wr = (tgl_s ^ tgl_q) & spi_sel_s;

    // Write port selection, parallel path first
    wire              wr_go   = par_wr | spi_wr;
    wire              wr_chan = par_wr ? sel_chan : wreq_hold.chan;
    wire [ADDR_W-1:0] wr_addr = par_wr ? addr_s
                                       : wreq_hold.addr[ADDR_W-1:0];
    wire [7:0]        wr_data = par_wr ? data_s : wreq_hold.data;

    ////////////////////////////////////////////////////////////////////////
    // Channel register files

    localparam logic [ADDR_W-1:0] IDX_STATUS =
        ADDR_W'(DCHP_REG_IRQ_STATUS);
    localparam logic [ADDR_W-1:0] IDX_MASK   = ADDR_W'(DCHP_REG_IRQ_MASK);
    localparam logic [ADDR_W-1:0] IDX_GLOBAL = ADDR_W'(DCHP_REG_GLOBAL);

    logic [7:0]    regs      [2][DEPTH];
    logic [7:0]    next_regs [2][DEPTH];
    dchp_events_s  evt       [2];

    assign evt[0] = chan1_events_in;
    assign evt[1] = chan2_events_in;

    // Next contents: sticky status with write-one-to-clear, set wins
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < DEPTH; a++) begin
                next_regs[c][a] = regs[c][a];
                if (wr_go && wr_chan == c[0] && wr_addr == a[ADDR_W-1:0]) begin
                    next_regs[c][a] = wr_data;
                end
            end
            next_regs[c][IDX_STATUS] = regs[c][IDX_STATUS];
            if (wr_go && wr_chan == c[0] && wr_addr == IDX_STATUS) begin
                next_regs[c][IDX_STATUS] = regs[c][IDX_STATUS] & ~wr_data;
            end
            next_regs[c][IDX_STATUS][DCHP_EVT_W-1:0] =
                next_regs[c][IDX_STATUS][DCHP_EVT_W-1:0] | evt[c];
        end
    end

    // Full device reset clears every register
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int c = 0; c < 2; c++) begin
                for (int a = 0; a < DEPTH; a++) begin
                    regs[c][a] <= DCHP_REG_RST;
                end
            end
        end else begin
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel read data and bus drive

    wire [7:0] rd_word = regs[sel_chan][addr_s];

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_oe_out <= 1'b0;
            data_out    <= DCHP_BYTE_ZERO;
        end else begin
            data_oe_out <= next_oe;
            data_out    <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gating

    logic [1:0] chan_pend;
    wire        glob_mask = regs[0][IDX_GLOBAL][DCHP_BIT_GLOBAL_MASK];

    // Per-source masks, then global mask
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            chan_pend[c] = |(regs[c][IDX_STATUS][DCHP_EVT_W-1:0] &
                             ~regs[c][IDX_MASK][DCHP_EVT_W-1:0]);
        end
    end

    wire pending = ~glob_mask & (|chan_pend);

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_oe_out    <= 1'b0;
            irq_out_n_out <= 1'b1;
        end else begin
            irq_oe_out    <= pending;
            irq_out_n_out <= ~pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SPI link domain

    wire cfg_cpol = data_s[DCHP_PIN_CPOL];
    wire cfg_cpha = data_s[DCHP_PIN_CPHA];
    wire cfg_swap = data_s[DCHP_PIN_SWAP];
    wire link_clk = spi_sclk_in ^ cfg_cpol ^ cfg_cpha;
    wire mosi     = data_in[DCHP_PIN_MOSI];
    wire spi_chan = chan1_select_n_in;
    wire frame_rst_n = resetn_in & spi_sel_s &
                       (chan1_select_n_in ^ chan2_select_n_in);

    dchp_spi_e                  spi_state;
    logic [4:0]                 bit_cnt;
    logic [15:0]                ctrl_sr;
    logic [7:0]                 data_sr;
    logic                       spi_rw;
    logic                       spi_burst;
    logic [DCHP_SPI_ADDR_W-1:0] spi_addr;

    wire [15:0] next_ctrl = {ctrl_sr[14:0], mosi};
    wire [7:0]  next_data = {data_sr[6:0], mosi};
    wire [DCHP_SPI_ADDR_W-1:0] ctrl_rev =
        {<<{next_ctrl[DCHP_CTRL_RW-1:DCHP_CTRL_BURST+1]}};
    wire [7:0]  data_rev = {<<{next_data}};
    wire [DCHP_SPI_ADDR_W-1:0] ctrl_addr = cfg_swap ? ctrl_rev
        : next_ctrl[DCHP_CTRL_RW-1:DCHP_CTRL_BURST+1];
    wire [7:0]  rx_byte  = cfg_swap ? data_rev : next_data;
    wire        data_end = (spi_state == DCHP_SPI_DATA) &&
                           (bit_cnt == DCHP_DATA_LAST);

    // Frame sequencer, cleared whenever the frame's select rises
    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            spi_state <= DCHP_SPI_CTRL;
            bit_cnt   <= '0;
            ctrl_sr   <= '0;
            data_sr   <= '0;
            spi_rw    <= 1'b0;
            spi_burst <= 1'b0;
            spi_addr  <= '0;
        end else begin
            case (spi_state)
                DCHP_SPI_CTRL: begin
                    ctrl_sr <= next_ctrl;
                    bit_cnt <= bit_cnt + DCHP_CNT_STEP;
                    if (bit_cnt == DCHP_CTRL_LAST) begin
                        spi_state <= DCHP_SPI_DATA;
                        bit_cnt   <= '0;
                        spi_rw    <= next_ctrl[DCHP_CTRL_RW];
                        spi_burst <= next_ctrl[DCHP_CTRL_BURST];
                        spi_addr  <= ctrl_addr;
                    end
                end
                DCHP_SPI_DATA: begin
                    data_sr <= next_data;
                    bit_cnt <= bit_cnt + DCHP_CNT_STEP;
                    if (data_end) begin
                        bit_cnt   <= '0;
                        spi_addr  <= spi_addr + 1'b1;
                        spi_state <= spi_burst ? DCHP_SPI_DATA
                                               : DCHP_SPI_DONE;
                    end
                end
                DCHP_SPI_DONE: begin
                    spi_state <= DCHP_SPI_DONE;
                end
                default: begin
                    spi_state <= DCHP_SPI_DONE;
                end
            endcase
        end
    end

    // Write request hand-off, kept through frame ends
    always_ff @(posedge link_clk or negedge resetn_in) begin
        if (!resetn_in) begin
            wreq_hold <= '0;
            wreq_tgl  <= 1'b0;
        end else if (data_end && !spi_rw) begin
            wreq_hold <= '{chan: spi_chan, addr: spi_addr, data: rx_byte};
            wreq_tgl  <= ~wreq_tgl;
        end
    end

    // Serial read data, shifted out on the opposite edge
    wire [7:0] spi_rd_word = regs[spi_chan][spi_addr[ADDR_W-1:0]];
    wire [2:0] tx_idx      = cfg_swap ? bit_cnt[2:0]
                                      : DCHP_DATA_MSB - bit_cnt[2:0];

    always_ff @(negedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            miso_oe_out <= 1'b0;
            miso_out    <= 1'b0;
        end else begin
            miso_oe_out <= (spi_state == DCHP_SPI_DATA) && spi_rw;
            miso_out    <= spi_rd_word[tx_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    bus_release_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (cs1_n_s && cs2_n_s) |=> !data_oe_out)
        else $error("Data bus driven with no channel selected");

    read_drive_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (par_mode && sel_any && rd_req)
            |=> data_oe_out && data_out == $past(rd_word))
        else $error("Read did not drive addressed register");

    write_capture_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (par_wr && addr_s != IDX_STATUS)
            |=> regs[$past(sel_chan)][$past(addr_s)] == $past(data_s))
        else $error("Parallel write not stored");

    strobe_ignore_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        !sel_any |-> !par_wr ##1 !data_oe_out)
        else $error("Strobe acted without a channel select");

    spi_quiet_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        spi_sel_s[*2] |-> !data_oe_out && !par_wr)
        else $error("Parallel access acted in SPI mode");

    style_read_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (par_mode && sel_any && bts_s && !strobe_n_s && !dir_n_s)
            |=> !data_oe_out)
        else $error("Strobe with write direction drove the bus");

    irq_raise_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(pending) |=> irq_oe_out && !irq_out_n_out)
        else $error("Unmasked event did not raise interrupt");

    irq_sticky_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (regs[0][IDX_STATUS][0] && !(wr_go && !wr_chan &&
            wr_addr == IDX_STATUS && wr_data[0]))
            |=> regs[0][IDX_STATUS][0])
        else $error("Pending status lost without acknowledge");

    global_mask_a: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        glob_mask |=> !irq_oe_out && irq_out_n_out)
        else $error("Interrupt escaped the global mask");

endmodule

/* File: dchp_pkg.sv */
// Shared constants and types for the dual channel host port.
// Assumes one 8-bit register file per channel, reached by parallel or SPI.
package dchp_pkg;

    // Data path and serial framing
    localparam int         DCHP_DATA_W      = 8;
    localparam int         DCHP_SPI_ADDR_W  = 14;
    localparam logic [4:0] DCHP_CTRL_LAST   = 5'h0f;
    localparam logic [4:0] DCHP_DATA_LAST   = 5'h07;
    localparam logic [4:0] DCHP_CNT_STEP    = 5'h01;
    localparam logic [2:0] DCHP_DATA_MSB    = 3'h7;
    localparam int         DCHP_CTRL_RW     = 15;
    localparam int         DCHP_CTRL_BURST  = 0;

    // Register indices inside each channel
    localparam int         DCHP_REG_IRQ_STATUS = 0;
    localparam int         DCHP_REG_IRQ_MASK   = 1;
    localparam int         DCHP_REG_GLOBAL     = 2;
    localparam int         DCHP_BIT_GLOBAL_MASK = 0;
    localparam logic [7:0] DCHP_REG_RST        = 8'h00;
    localparam logic [7:0] DCHP_BYTE_ZERO      = 8'h00;

    // Data pins that carry serial functions in SPI mode
    localparam int         DCHP_PIN_MOSI = 1;
    localparam int         DCHP_PIN_SWAP = 5;
    localparam int         DCHP_PIN_CPHA = 6;
    localparam int         DCHP_PIN_CPOL = 7;

    // Interrupt sources of one channel, framer in bit 0
    localparam int         DCHP_EVT_W = 3;
    typedef struct packed {
        logic bert;
        logic liu;
        logic framer;
    } dchp_events_s;

    // Serial write request passed to the register clock domain
    typedef struct packed {
        logic                       chan;
        logic [DCHP_SPI_ADDR_W-1:0] addr;
        logic [DCHP_DATA_W-1:0]     data;
    } dchp_wreq_s;

    // Serial frame states
    typedef enum logic [1:0] {
        DCHP_SPI_CTRL = 2'b00,
        DCHP_SPI_DATA = 2'b01,
        DCHP_SPI_DONE = 2'b11
    } dchp_spi_e;

endpackage

/* File: dchp_host_model.sv */
// Host model: drives parallel accesses and SPI frames onto the pins.
// Assumes the bench resolves the shared data pins from every enable.
module dchp_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] pins_in,
    output logic            chan1_select_n_out,
    output logic            chan2_select_n_out,
    output logic            read_or_data_strobe_n_out,
    output logic            write_or_direction_n_out,
    output logic [3:0]      addr_out,
    output logic [7:0]      d_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] drv = 8'h00;
    logic [7:0] pat = 8'h5a;
    logic       oe  = 1'b0;
    logic       spi = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Released lines show a changing pattern, never the last value
    always @(negedge clk_in) pat <= ~pat;
    assign d_out = oe ? {drv[7:1], spi ? pat[0] : drv[0]} : pat;

    // Idle bus at time zero
    initial begin
        chan1_select_n_out        = 1'b1;
        chan2_select_n_out        = 1'b1;
        read_or_data_strobe_n_out = 1'b1;
        write_or_direction_n_out  = 1'b1;
        addr_out                  = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Select one channel or none, never both
    task automatic pick(input int ch);
        chan1_select_n_out = (ch != 1);
        chan2_select_n_out = (ch != 2);
    endtask

    // One parallel access; strobes held 5 cycles, data 4 cycles past rise
    task automatic par(input int ch, input logic style, input logic wr,
                       input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk_in);
        spi = 1'b0;
        addr_out = a;
        drv = d;
        oe = wr;
        write_or_direction_n_out = style ? !wr : 1'b1;
        pick(ch);
        @(negedge clk_in);
        if (style || !wr) read_or_data_strobe_n_out = 1'b0;
        else write_or_direction_n_out = 1'b0;
        repeat (5) @(negedge clk_in);
        q = pins_in;
        read_or_data_strobe_n_out = 1'b1;
        if (!style) write_or_direction_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        pick(0);
        write_or_direction_n_out = 1'b1;
        oe = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask

    // One SPI frame, 32 ns link clock, mode = {burst, polarity, phase, swap}
    // A burst frame sends d, then its inverse to the next register
    task automatic spi_frame(input int ch, input logic wr,
                             input logic [3:0] a, input logic [7:0] d,
                             input logic [3:0] mode, output logic [7:0] q);
        logic [0:31] seq;
        logic [13:0] a14;
        logic        burst;
        logic        cpol;
        logic        cpha;
        logic        swap;
        {burst, cpol, cpha, swap} = mode;
        a14 = {10'h000, a};
        seq[0] = !wr;
        seq[15] = burst;
        for (int k = 0; k < 14; k++) seq[1+k] = a14[swap ? k : 13-k];
        for (int k = 0; k < 8; k++) seq[16+k] = d[swap ? k : 7-k];
        for (int k = 0; k < 8; k++) seq[24+k] = !d[swap ? k : 7-k];
        @(negedge clk_in);
        spi = 1'b1;
        oe = 1'b1;
        drv = {cpol, cpha, swap, 2'b00, cpol, 2'b00};
        repeat (6) @(negedge clk_in);
        pick(ch);
        #16;
        for (int i = 0; i < (burst ? 32 : 24); i++) begin
            if (cpha) drv[2] = !cpol;
            drv[1] = seq[i];
            #16;
            if (i > 15 && i < 24) q[swap ? i-16 : 23-i] = pins_in[0];
            drv[2] = cpha ? cpol : !cpol;
            #16;
            if (!cpha) drv[2] = cpol;
        end
        pick(0);
        repeat (8) @(negedge clk_in);
    endtask
endmodule

/* File: tb_dual_channel_host_port.sv */
// Bench for the dual channel host port: parallel, SPI and interrupt paths.
// Assumes the host model file and a 4-bit register address.
module tb_dual_channel_host_port
    import dchp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk         = 1'b0;
    logic         rst_n       = 1'b0;
    logic         spi_sel     = 1'b0;
    logic         style       = 1'b0;
    dchp_events_s ev1         = '0;
    dchp_events_s ev2         = '0;
    logic [7:0]   mem [1:2][16];
    int           seed        = 37;
    int           idle        = 0;
    int           miscompares = 0;
    int           num_checks  = 0;
    wire  [7:0]   host_d, pins, data_out;
    wire  [3:0]   addr;
    wire          cs1_n, cs2_n, rds_n, wrd_n, data_oe, miso, miso_oe;
    wire          irq_n, irq_oe;

    // Shared data pins resolved from all drivers
    assign pins = data_oe ? data_out
                          : {host_d[7:1], miso_oe ? miso : host_d[0]};

    dchp_host_port #(.ADDR_W(4)) u_dut (
        .ref_clk_in               (clk),
        .resetn_in                (rst_n),
        .spi_sclk_in              (pins[2]),
        .addr_in                  (addr),
        .data_in                  (pins),
        .data_out                 (data_out),
        .data_oe_out              (data_oe),
        .miso_out                 (miso),
        .miso_oe_out              (miso_oe),
        .chan1_select_n_in        (cs1_n),
        .chan2_select_n_in        (cs2_n),
        .read_or_data_strobe_n_in (rds_n),
        .write_or_direction_n_in  (wrd_n),
        .bus_style_select_in      (style),
        .spi_select_in            (spi_sel),
        .chan1_events_in          (ev1),
        .chan2_events_in          (ev2),
        .irq_out_n_out            (irq_n),
        .irq_oe_out               (irq_oe)
    );

    dchp_host_model u_host (
        .clk_in                    (clk),
        .pins_in                   (pins),
        .chan1_select_n_out        (cs1_n),
        .chan2_select_n_out        (cs2_n),
        .read_or_data_strobe_n_out (rds_n),
        .write_or_direction_n_out  (wrd_n),
        .addr_out                  (addr),
        .d_out                     (host_d)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial forever #5 clk = ~clk;
    initial begin
        #500000;
        miscompares++;
        close_out();
    end

    // Pins must stay released while no channel is selected
    always @(negedge clk) begin
        idle = (cs1_n && cs2_n) ? idle + 1 : 0;
        if (idle > 4) chk_bit(data_oe | miso_oe, 1'b0);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Expected register contents
    function automatic logic [7:0] exp_rd(input int ch, input logic [3:0] a);
        return mem[ch][a];
    endfunction
    function automatic logic [3:0] rnd_addr();
        return 4'h3 + 4'(($random(seed) & 32'h7fffffff) % 13);
    endfunction
    task automatic clear_mem();
        foreach (mem[i, j]) mem[i][j] = 8'h00;
    endtask

    // Register accesses and interrupt events
    task automatic wr(input int ch, input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.par(ch, style, 1'b1, a, d, q);
        if (ch != 0) mem[ch][a] = d;
    endtask
    task automatic rd(input int ch, input logic [3:0] a, output logic [7:0] q);
        u_host.par(ch, style, 1'b0, a, 8'h00, q);
    endtask
    task automatic pulse(input int ch, input logic [2:0] b);
        @(negedge clk);
        if (ch == 1) ev1 = b;
        else ev2 = b;
        @(negedge clk);
        ev1 = '0;
        ev2 = '0;
        repeat (4) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] q;
        logic [3:0] a;
        logic [7:0] d;
        clear_mem();
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_bit(irq_oe, 1'b0);
        chk_bit(irq_n, 1'b1);
        for (int s = 0; s < 2; s++) begin
            style = s[0];
            for (int n = 0; n < 4; n++) begin
                a = rnd_addr();
                d = 8'($random(seed));
                wr(1, a, d);
                wr(2, a, ~d);
                wr(0, a, d ^ 8'h3c);
                rd(1, a, q);
                chk_byte(q, exp_rd(1, a));
                rd(2, a, q);
                chk_byte(q, exp_rd(2, a));
            end
        end
        // Parallel strobes while in SPI mode
        spi_sel = 1'b1;
        u_host.par(1, style, 1'b1, a, 8'h99, q);
        spi_sel = 1'b0;
        rd(1, a, q);
        chk_byte(q, exp_rd(1, a));
        // Every clock mode and bit order over SPI
        for (int m = 0; m < 8; m++) begin
            a = rnd_addr();
            d = 8'($random(seed));
            spi_sel = 1'b1;
            u_host.spi_frame(m % 2 + 1, 1'b1, a, d, {1'b0, m[2:0]}, q);
            mem[m%2+1][a] = d;
            u_host.spi_frame(m % 2 + 1, 1'b0, a, 8'h00, {1'b0, m[2:0]}, q);
            chk_byte(q, d);
            chk_bit(miso_oe, 1'b0);
            spi_sel = 1'b0;
            rd(m % 2 + 1, a, q);
            chk_byte(q, exp_rd(m % 2 + 1, a));
        end
        // Two-byte burst write lands in consecutive registers
        a = rnd_addr() - 4'h1;
        d = 8'($random(seed));
        spi_sel = 1'b1;
        u_host.spi_frame(2, 1'b1, a, d, {1'b1, 3'($random(seed))}, q);
        mem[2][a] = d;
        mem[2][a+4'h1] = ~d;
        spi_sel = 1'b0;
        rd(2, a, q);
        chk_byte(q, exp_rd(2, a));
        rd(2, a + 4'h1, q);
        chk_byte(q, exp_rd(2, a + 4'h1));
        // Each source of each channel, unmasked then masked
        for (int n = 0; n < 6; n++) begin
            pulse(n / 3 + 1, 3'b001 << (n % 3));
            chk_bit(irq_n, 1'b0);
            rd(n / 3 + 1, 4'h0, q);
            chk_byte(q, {5'h00, 3'b001 << (n % 3)});
            wr(n / 3 + 1, 4'h0, q);
            chk_bit(irq_oe, 1'b0);
            wr(n / 3 + 1, 4'h1, q);
            pulse(n / 3 + 1, q[2:0]);
            chk_bit(irq_oe, 1'b0);
            wr(n / 3 + 1, 4'h0, q);
            wr(n / 3 + 1, 4'h1, 8'h00);
        end
        // Global mask, then two pending events cleared one at a time
        wr(1, 4'h2, 8'h01);
        pulse(2, 3'b001);
        chk_bit(irq_oe, 1'b0);
        wr(2, 4'h0, 8'h01);
        wr(1, 4'h2, 8'h00);
        pulse(1, 3'b011);
        wr(1, 4'h0, 8'h01);
        chk_bit(irq_oe, 1'b1);
        wr(1, 4'h0, 8'h02);
        chk_bit(irq_oe, 1'b0);
        // Reset in mid-run clears registers and pending events
        wr(2, 4'h5, 8'ha5);
        pulse(1, 3'b100);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        clear_mem();
        repeat (3) @(negedge clk);
        chk_bit(irq_oe, 1'b0);
        rd(2, 4'h5, q);
        chk_byte(q, exp_rd(2, 4'h5));
        close_out();
    end
endmodule
